// [verilog/rufs_top.sv]
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rufs_params.svh"
// Notes on behaviour
// RULE_01 - Unserviced watchdog expires, factory image reloads
// RULE_02 - Watchdog fallback from image one: 1010
// RULE_03 - Watchdog fallback from image two: 0011
// RULE_04 - Restart pin low in application: cause 10000
// RULE_05 - Restart fallback from image one: 1110
// RULE_06 - Restart fallback from image two: 0001
// RULE_07 - Failed load pulls status low, cause 00100
// RULE_08 - Status failure shows 1001 or 0100
// RULE_09 - CRC load error: cause 01000, shows 0110
// RULE_10 - Power-up runs factory, indicators 1111
// RULE_11 - Update button starts reconfiguration to application
// RULE_12 - Successive updates alternate image one, two
// RULE_13 - Off button stops servicing and blinking
// RULE_14 - State on monitor; reaches 0x09, 0x02
// RULE_15 - Watchdog time-out records cause 00010
// RULE_16 - Power-up factory reports cause 00000
// RULE_17 - Service watchdog every 33554432 board cycles
// RULE_18 - Cause read only while circuitry idle
module rufs_top #(
   parameter logic [31:0] WDOG_CYCLES = 32'(`RUFS_WDOG_CYCLES),
   parameter logic [31:0] SVC_CYCLES = 32'(`RUFS_SVC_CYCLES)
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire rufs_pkg::rufs_apb_req_s APB_REQ,
   output rufs_pkg::rufs_apb_rsp_s APB_RSP,
   input wire logic CONFIG_RESTART_N,
   input wire logic UPDATE_BUTTON,
   input wire logic WDOG_SERVICE_OFF_BUTTON,
   input wire logic LOAD_FAIL,
   input wire logic LOAD_CRC_ERR,
   input wire logic CONFIG_STATUS_N_I,
   output logic CONFIG_STATUS_N_O,
   output logic CONFIG_STATUS_N_OE_N,
   output logic [3:0] LED,
   output logic [7:0] STATE_MON
);
   import rufs_pkg::*;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic upd_prev;
   logic off_prev;
   wire logic restart_n_s = sync2[0];
   wire logic upd_s = sync2[1];
   wire logic off_s = sync2[2];
   wire logic fail_s = sync2[3];
   wire logic crc_s = sync2[4];
   wire logic status_in_s = sync2[5];
   wire logic upd_edge = upd_s & ~upd_prev;
   wire logic off_edge = off_s & ~off_prev;

   // Two stages per pin; only the second stage is looked at
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         sync1 <= 6'h3f;
         sync2 <= 6'h3f;
         upd_prev <= 1'b1;
         off_prev <= 1'b1;
      end else begin
         sync1 <= {CONFIG_STATUS_N_I, LOAD_CRC_ERR, LOAD_FAIL, WDOG_SERVICE_OFF_BUTTON,
                   UPDATE_BUTTON, CONFIG_RESTART_N};
         sync2 <= sync1;
         upd_prev <= upd_s;
         off_prev <= off_s;
      end
   end

   // ****************************************
   // Indicator decode
   // ****************************************
   function automatic logic [3:0] led_pattern(input logic [4:0] cause, input rufs_img_e img);
      logic a2;
      a2 = (img == IMG_APP2);
      case (cause)
         `RUFS_CAUSE_WDOG: led_pattern = a2 ? `RUFS_LED_WDOG_A2 : `RUFS_LED_WDOG_A1;
         `RUFS_CAUSE_RESTART: led_pattern = a2 ? `RUFS_LED_RST_A2 : `RUFS_LED_RST_A1;
         `RUFS_CAUSE_STATUS: led_pattern = a2 ? `RUFS_LED_STAT_A2 : `RUFS_LED_STAT_A1;
         `RUFS_CAUSE_CRC: led_pattern = `RUFS_LED_CRC;
         default: led_pattern = `RUFS_LED_FACTORY;
      endcase
   endfunction : led_pattern

   // ****************************************
   // Image sequencer
   // ****************************************
   rufs_state_e state;
   rufs_state_e next_state;
   rufs_img_e img;
   rufs_img_e next_img;
   rufs_img_e target;
   rufs_img_e next_target;
   logic [4:0] cause;
   logic [4:0] next_cause;
   logic [3:0] leds;
   logic [3:0] next_leds;
   logic [7:0] cnt;
   logic [7:0] next_cnt;
   logic [31:0] wd_cnt;
   logic [31:0] next_wd_cnt;
   logic [31:0] svc_cnt;
   logic [31:0] next_svc_cnt;
   logic svc_on;
   logic next_svc_on;
   logic stat_low;
   logic next_stat_low;
   logic ctrl_svc_en;
   logic svc_pulse;

   // Watchdog restart strobe, only while servicing is allowed
   assign svc_pulse = (state == ST_APP) && svc_on && ctrl_svc_en
                      && (svc_cnt == SVC_CYCLES - 32'h0000_0001); // RULE_17

   // Next-state logic of the image sequencer
   always_comb begin
      next_state = state;
      next_img = img;
      next_target = target;
      next_cause = cause;
      next_leds = leds;
      next_cnt = (cnt != 8'h00) ? cnt - 8'h01 : cnt;
      next_wd_cnt = wd_cnt;
      next_svc_cnt = svc_cnt;
      next_svc_on = svc_on;
      next_stat_low = stat_low;
      case (state)
         ST_FACTORY: begin
            if (upd_edge) begin
               next_state = ST_WR_WDEN; // RULE_11
            end
         end
         ST_WR_WDEN: next_state = ST_WR_WDTO;
         ST_WR_WDTO: next_state = ST_WR_ADDR;
         ST_WR_ADDR: begin
            next_img = target;
            next_target = (target == IMG_APP1) ? IMG_APP2 : IMG_APP1; // RULE_12
            next_state = ST_RECONFIG; // RULE_14
         end
         ST_RECONFIG: begin
            next_cnt = `RUFS_LOAD_CYCLES;
            next_state = ST_LOADING;
         end
         ST_LOADING: begin
            if (cnt == 8'h00) begin
               next_cnt = `RUFS_BUSY_CYCLES;
               if (fail_s) begin
                  next_cause = `RUFS_CAUSE_STATUS; // RULE_07
                  next_stat_low = 1'b1; // RULE_07
                  next_state = ST_RD_CAUSE;
               end else if (crc_s) begin
                  next_cause = `RUFS_CAUSE_CRC; // RULE_09
                  next_state = ST_RD_CAUSE;
               end else begin
                  next_leds = `RUFS_LED_APP;
                  next_wd_cnt = 32'h0000_0000;
                  next_svc_cnt = 32'h0000_0000;
                  next_svc_on = 1'b1;
                  next_state = ST_APP; // RULE_14
               end
            end
         end
         ST_APP: begin
            next_wd_cnt = wd_cnt + 32'h0000_0001;
            if (svc_on && ctrl_svc_en) begin
               next_svc_cnt = svc_pulse ? 32'h0000_0000 : svc_cnt + 32'h0000_0001;
            end
            if (svc_pulse) begin
               next_wd_cnt = 32'h0000_0000; // RULE_17
               next_leds[img == IMG_APP2 ? 1 : 0] = ~leds[img == IMG_APP2 ? 1 : 0];
            end
            if (off_edge) begin
               next_svc_on = 1'b0; // RULE_13
            end
            // External restart outranks a watchdog expiry in the same cycle
            if (!restart_n_s) begin
               next_cause = `RUFS_CAUSE_RESTART; // RULE_04
               next_cnt = `RUFS_BUSY_CYCLES;
               next_state = ST_RD_CAUSE;
            end else if (wd_cnt >= WDOG_CYCLES - 32'h0000_0001) begin
               next_cause = `RUFS_CAUSE_WDOG; // RULE_01 RULE_15
               next_cnt = `RUFS_BUSY_CYCLES;
               next_state = ST_RD_CAUSE;
            end
         end
         ST_RD_CAUSE: begin
            // Cause is sampled only once the update circuitry is idle
            if (cnt == 8'h00) begin
               next_leds = led_pattern(cause, img); // RULE_02 RULE_03 RULE_05 RULE_06 RULE_08 RULE_09
               next_stat_low = 1'b0;
               next_state = ST_FACTORY;
            end
         end
         default: next_state = ST_FACTORY;
      endcase
   end

   // Sequencer registers; power-up lands in the factory image
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         state <= ST_FACTORY;
         img <= IMG_FACTORY;
         target <= IMG_APP1;
         cause <= `RUFS_CAUSE_POWERUP; // RULE_16
         leds <= `RUFS_LED_FACTORY; // RULE_10
         cnt <= 8'h00;
         wd_cnt <= 32'h0000_0000;
         svc_cnt <= 32'h0000_0000;
         svc_on <= 1'b0;
         stat_low <= 1'b0;
      end else begin
         state <= next_state;
         img <= next_img;
         target <= next_target;
         cause <= next_cause;
         leds <= next_leds;
         cnt <= next_cnt;
         wd_cnt <= next_wd_cnt;
         svc_cnt <= next_svc_cnt;
         svc_on <= next_svc_on;
         stat_low <= next_stat_low;
      end
   end

   // Status pin is open drain: only ever pulled low
   assign CONFIG_STATUS_N_O = 1'b0;
   assign CONFIG_STATUS_N_OE_N = ~stat_low;
   assign LED = leds;
   assign STATE_MON = state;

   // ****************************************
   // APB slave
   // ****************************************
   logic next_ctrl_svc_en;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic slverr;
   logic next_slverr;
   wire logic apb_acc = APB_REQ.psel & APB_REQ.penable;

   // Zero-wait slave; unmapped addresses answer with an error
   always_comb begin
      next_ctrl_svc_en = ctrl_svc_en;
      next_rdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (APB_REQ.psel && !APB_REQ.penable) begin
         case (APB_REQ.paddr)
            `RUFS_ADDR_CTRL: next_rdata[`RUFS_CTRL_SVC_EN_BIT] = ctrl_svc_en;
            `RUFS_ADDR_STATUS: begin
               next_rdata[`RUFS_ST_CAUSE_LSB +: 5] = cause;
               next_rdata[`RUFS_ST_IMG_LSB +: 2] = (state == ST_APP) ? img : IMG_FACTORY;
               next_rdata[`RUFS_ST_LED_LSB +: 4] = leds;
               next_rdata[`RUFS_ST_MON_LSB +: 8] = state;
            end
            default: next_slverr = 1'b1;
         endcase
      end else if (apb_acc) begin
         next_rdata = rdata;
         next_slverr = slverr;
      end
      if (apb_acc && APB_REQ.pwrite && APB_REQ.paddr == `RUFS_ADDR_CTRL) begin
         next_ctrl_svc_en = APB_REQ.pwdata[`RUFS_CTRL_SVC_EN_BIT];
      end
   end

   // Setup phase captures the read value, access phase presents it
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         ctrl_svc_en <= `RUFS_CTRL_RST;
         rdata <= 32'h0000_0000;
         slverr <= 1'b0;
      end else begin
         ctrl_svc_en <= next_ctrl_svc_en;
         rdata <= next_rdata;
         slverr <= next_slverr;
      end
   end

   // One driver for the whole response; pready never inserts a wait state
   assign APB_RSP = '{pready: 1'b1,
                      prdata: apb_acc ? rdata : 32'h0000_0000,
                      pslverr: apb_acc & slverr};

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   chk_powerup_state: assert property ($rose(RSTN) |-> leds == 4'hf && cause == 5'h00 && state == ST_FACTORY) // RULE_10 RULE_16
      else $error("power-up state wrong");
   chk_wdog_expiry: assert property (state == ST_APP && restart_n_s && wd_cnt >= WDOG_CYCLES - 32'h0000_0001
      |=> state == ST_RD_CAUSE && cause == 5'h02) // RULE_01 RULE_15
      else $error("watchdog expiry missed");
   chk_wdog_led_a1: assert property (state == ST_RD_CAUSE && cnt == 8'h00 && cause == 5'h02 && img == IMG_APP1
      |=> leds == 4'ha) // RULE_02
      else $error("wrong watchdog code image one");
   chk_wdog_led_a2: assert property (state == ST_RD_CAUSE && cnt == 8'h00 && cause == 5'h02 && img == IMG_APP2
      |=> leds == 4'h3) // RULE_03
      else $error("wrong watchdog code image two");
   chk_restart_cause: assert property (state == ST_APP && !restart_n_s |=> cause == 5'h10 ##4 state == ST_RD_CAUSE
      ##1 state == ST_FACTORY && leds == (img == IMG_APP2 ? 4'h1 : 4'he)) // RULE_04 RULE_05 RULE_06
      else $error("restart fallback wrong");
   chk_load_fail: assert property (state == ST_LOADING && cnt == 8'h00 && fail_s
      |=> cause == 5'h04 && !CONFIG_STATUS_N_OE_N ##5 leds == (img == IMG_APP2 ? 4'h4 : 4'h9)) // RULE_07 RULE_08
      else $error("status failure fallback wrong");
   chk_crc_fallback: assert property (state == ST_LOADING && cnt == 8'h00 && !fail_s && crc_s
      |=> cause == 5'h08 ##5 leds == 4'h6) // RULE_09
      else $error("crc fallback wrong");
   chk_update_seq: assert property (state == ST_FACTORY && upd_edge |=> ##3 STATE_MON == 8'h09) // RULE_11 RULE_14
      else $error("update sequence wrong");
   chk_target_alt: assert property (state == ST_WR_ADDR |=> target != $past(target) && img == $past(target)) // RULE_12
      else $error("target did not alternate");
   // Stability is judged one cycle on, so a toggle launched with the button is not flagged
   chk_svc_stop: assert property (state == ST_APP && !svc_on |-> !svc_pulse ##1 $stable(leds)) // RULE_13
      else $error("servicing after off button");
   chk_svc_restart: assert property (svc_pulse |=> wd_cnt == 32'h0000_0000 && svc_cnt == 32'h0000_0000) // RULE_17
      else $error("watchdog not restarted");
   chk_cause_idle: assert property (state == ST_RD_CAUSE && cnt != 8'h00 |=> $stable(leds)) // RULE_18
      else $error("cause read while busy");
   // Pin readback must show the pull-down once it has passed the synchroniser
   chk_status_readback: assert property ($rose(stat_low) |-> ##2 !status_in_s) // RULE_07
      else $error("status pin not seen low");

   cov_wdog_fallback: cover property (state == ST_APP ##1 state == ST_RD_CAUSE && cause == 5'h02);
   cov_restart_fallback: cover property (state == ST_APP ##1 cause == 5'h10);
   cov_app_entry: cover property (state == ST_LOADING ##1 state == ST_APP);
endmodule : rufs_top
`default_nettype wire

// [verilog/rufs_params.svh]
`ifndef RUFS_PARAMS_SVH
`define RUFS_PARAMS_SVH
// ****************************************
// Register map
// ****************************************
`define RUFS_ADDR_CTRL 12'h000
`define RUFS_ADDR_STATUS 12'h004
`define RUFS_CTRL_RST 1'h1
`define RUFS_CTRL_SVC_EN_BIT 0
`define RUFS_ST_CAUSE_LSB 0
`define RUFS_ST_IMG_LSB 8
`define RUFS_ST_LED_LSB 12
`define RUFS_ST_MON_LSB 16
// ****************************************
// Reconfiguration source codes
// ****************************************
`define RUFS_CAUSE_POWERUP 5'h00
`define RUFS_CAUSE_WDOG 5'h02
`define RUFS_CAUSE_STATUS 5'h04
`define RUFS_CAUSE_CRC 5'h08
`define RUFS_CAUSE_RESTART 5'h10
// ****************************************
// Indicator patterns
// ****************************************
`define RUFS_LED_FACTORY 4'hf
`define RUFS_LED_WDOG_A1 4'ha
`define RUFS_LED_WDOG_A2 4'h3
`define RUFS_LED_RST_A1 4'he
`define RUFS_LED_RST_A2 4'h1
`define RUFS_LED_STAT_A1 4'h9
`define RUFS_LED_STAT_A2 4'h4
`define RUFS_LED_CRC 4'h6
`define RUFS_LED_APP 4'h0
// ****************************************
// Timing
// ****************************************
`define RUFS_CLK_NS 40
`define RUFS_OSC_NS 100
`define RUFS_WDOG_TICKS 40894472
`define RUFS_BRD_NS 20
`define RUFS_SVC_BRD_CYCLES 33554432
`define RUFS_WDOG_CYCLES ((64'd`RUFS_WDOG_TICKS * `RUFS_OSC_NS) / `RUFS_CLK_NS)
`define RUFS_SVC_CYCLES ((64'd`RUFS_SVC_BRD_CYCLES * `RUFS_BRD_NS) / `RUFS_CLK_NS)
`define RUFS_BUSY_CYCLES 8'h04
`define RUFS_LOAD_CYCLES 8'h10
`endif

// [verilog/rufs_pkg.sv]
package rufs_pkg;
   typedef enum logic [7:0] {
      ST_FACTORY  = 8'h00,
      ST_RD_CAUSE = 8'h01,
      ST_APP      = 8'h02,
      ST_WR_WDEN  = 8'h05,
      ST_WR_WDTO  = 8'h06,
      ST_WR_ADDR  = 8'h07,
      ST_RECONFIG = 8'h09,
      ST_LOADING  = 8'h0a
   } rufs_state_e;
   typedef enum logic [1:0] {
      IMG_FACTORY = 2'h0,
      IMG_APP1    = 2'h1,
      IMG_APP2    = 2'h2
   } rufs_img_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } rufs_apb_req_s;
   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } rufs_apb_rsp_s;
endpackage : rufs_pkg

// [tb/rufs_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Flash and update circuitry stand-in
// ****************************************
module rufs_flash_model (
   input wire logic [7:0] state_mon,
   input wire logic [1:0] fault,
   input wire logic oe_n,
   input wire logic pin_o,
   output logic load_fail,
   output logic load_crc_err,
   output logic status_pin
);
   // Faults appear only while an image loads, so a stale fault cannot leak
   assign load_fail = (state_mon == 8'h0a) && (fault == 2'h1);
   assign load_crc_err = (state_mon == 8'h0a) && (fault == 2'h2);
   // Open-drain pin with pull-up: low only while the device pulls it
   assign status_pin = oe_n ? 1'b1 : pin_o;
endmodule : rufs_flash_model
`default_nettype wire

// [tb/rufs_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rufs_top_tb;
   import rufs_pkg::*;
   logic ref_clk;
   logic rstn;
   rufs_apb_req_s apb_req;
   rufs_apb_rsp_s apb_rsp;
   logic restart_n, upd_btn, off_btn, load_fail, crc_err, stat_pin, stat_o, stat_oe_n;
   logic [3:0] led;
   logic [3:0] led_prev;
   logic [7:0] state_mon;
   logic [1:0] fault;
   int fail_count;
   int samples_checked;
   // ****************************************
   // Design and far side
   // ****************************************
   // Short counts keep the watchdog run brief; service period stays below expiry
   rufs_top #(.WDOG_CYCLES(32'h0000_00c8), .SVC_CYCLES(32'h0000_0032)) DUT (
      .REF_CLK(ref_clk), .RSTN(rstn), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
      .CONFIG_RESTART_N(restart_n), .UPDATE_BUTTON(upd_btn),
      .WDOG_SERVICE_OFF_BUTTON(off_btn), .LOAD_FAIL(load_fail), .LOAD_CRC_ERR(crc_err),
      .CONFIG_STATUS_N_I(stat_pin), .CONFIG_STATUS_N_O(stat_o),
      .CONFIG_STATUS_N_OE_N(stat_oe_n), .LED(led), .STATE_MON(state_mon));
   rufs_flash_model flash (.state_mon(state_mon), .fault(fault), .oe_n(stat_oe_n),
      .pin_o(stat_o), .load_fail(load_fail), .load_crc_err(crc_err), .status_pin(stat_pin));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic final_report();
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic give_up();
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, state_mon, 8'hff);
      final_report();
   endtask : give_up
   // One APB transfer; request held until pready is seen high
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] w,
                       input logic [31:0] exp, input logic exp_err);
      int i;
      @(posedge ref_clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: w};
      @(posedge ref_clk);
      apb_req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge ref_clk);
         if (apb_rsp.pready === 1'b1) break;
      end
      if (i == 20) give_up();
      if (!wr) check(apb_rsp.prdata, exp);
      check({31'h0, apb_rsp.pslverr}, {31'h0, exp_err});
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask : xfer
   task automatic wait_state(input logic [7:0] code);
      for (int i = 0; i < 2000; i++) begin
         @(posedge ref_clk);
         if (state_mon === code) return;
      end
      give_up();
   endtask : wait_state
   task automatic press(input bit which);
      @(posedge ref_clk);
      if (which) off_btn <= 1'b1; else upd_btn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      off_btn <= 1'b0;
      upd_btn <= 1'b0;
   endtask : press
   // Start an update; the sequencer must pass through the reconfig state
   task automatic update();
      press(1'b0);
      wait_state(8'h09);
   endtask : update
   // Indicators are judged only after the busy read of the cause has finished
   task automatic fallback(input logic [3:0] exp_led, input logic [4:0] cause);
      wait_state(8'h00);
      repeat (2) @(posedge ref_clk);
      check({28'h0, led}, {28'h0, exp_led});
      xfer(1'b0, 12'h004, 32'h0, {16'h0000, exp_led, 7'h00, cause}, 1'b0);
   endtask : fallback
   // Blink while serviced, survive past expiry, then stop servicing
   task automatic wdog(input int idx, input logic [3:0] exp_led);
      wait_state(8'h02);
      led_prev = led;
      repeat (50) @(posedge ref_clk);
      check({31'h0, led[idx] ^ led_prev[idx]}, 32'h0000_0001);
      repeat (250) @(posedge ref_clk);
      check({24'h0, state_mon}, 32'h0000_0002);
      press(1'b1);
      repeat (4) @(posedge ref_clk);
      led_prev = led;
      repeat (100) @(posedge ref_clk);
      check({28'h0, led}, {28'h0, led_prev});
      fallback(exp_led, 5'h02);
   endtask : wdog
   task automatic restart(input logic [3:0] exp_led);
      wait_state(8'h02);
      restart_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      restart_n <= 1'b1;
      fallback(exp_led, 5'h10);
   endtask : restart
   // Failed load: for a status failure (kind 1) the status pin must be pulled low before the factory image returns; a CRC error leaves it high
   task automatic bad_load(input logic [1:0] kind, input logic [3:0] exp_led);
      // Let an edge pass so the previous call's fault clear is not overwritten in one step
      @(posedge ref_clk);
      fault <= kind;
      update();
      wait_state(8'h01);
      if (kind == 2'h1) check({31'h0, stat_pin}, 32'h0000_0000);
      fallback(exp_led, (kind == 2'h1) ? 5'h04 : 5'h08);
      fault <= 2'h0;
   endtask : bad_load
   // ****************************************
   // Clock and main sequence
   // ****************************************
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      fail_count = 0;
      samples_checked = 0;
      rstn = 1'b0;
      apb_req = '0;
      restart_n = 1'b1;
      upd_btn = 1'b0;
      off_btn = 1'b0;
      fault = 2'h0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      check({20'h0, led, state_mon}, 32'h0000_0f00);
      xfer(1'b0, 12'h004, 32'h0, 32'h0000_f000, 1'b0);
      xfer(1'b0, 12'h000, 32'h0, 32'h0000_0001, 1'b0);
      xfer(1'b1, 12'h000, 32'h0000_0000, 32'h0, 1'b0);
      xfer(1'b0, 12'h000, 32'h0, 32'h0000_0000, 1'b0);
      xfer(1'b1, 12'h000, 32'h0000_0001, 32'h0, 1'b0);
      xfer(1'b1, 12'h004, 32'hffff_ffff, 32'h0, 1'b0);
      xfer(1'b0, 12'h004, 32'h0, 32'h0000_f000, 1'b0);
      xfer(1'b0, 12'h008, 32'h0, 32'h0000_0000, 1'b1);
      xfer(1'b1, 12'h008, 32'h0000_0000, 32'h0, 1'b1);
      update();
      wdog(0, 4'ha);
      update();
      wdog(1, 4'h3);
      update();
      restart(4'he);
      update();
      restart(4'h1);
      bad_load(2'h1, 4'h9);
      bad_load(2'h1, 4'h4);
      bad_load(2'h2, 4'h6);
      bad_load(2'h2, 4'h6);
      final_report();
   end
endmodule : rufs_top_tb
`default_nettype wire
